// [core/gov_discrete_io.sv]
`timescale 1ns/1ps
module gov_discrete_io
	import gov_io_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_B,
	// Contact inputs A, B, C
	input wire logic SPARE_A_IN,
	input wire logic ALARM_RESET_IN,
	input wire logic SPEED_FAIL_OVR_IN,
	// Speed pickup health
	input wire logic SPEED_PICKUP_ONE_FAIL,
	input wire logic SPEED_PICKUP_TWO_FAIL,
	// Configuration
	input wire logic REVERSE_ACTING,
	input wire logic [ALARM_W-1:0] ALARM_CFG,
	input wire logic [SHUT_W-1:0] SHUT_CFG,
	// Raw abnormal conditions
	input wire logic [ALARM_W-1:0] ALARM_COND,
	input wire logic [SHUT_W-1:0] SHUT_COND,
	// Software reset switch from service tools
	input wire logic SW_RESET,
	// Control values for the analog outputs
	input wire logic [15:0] ENGINE_SPEED,
	input wire logic [15:0] SPEED_REF,
	input wire logic [15:0] FUEL_DEMAND,
	input wire logic [15:0] REV_FUEL_DEMAND,
	input wire logic [15:0] TORSION_LEVEL,
	input wire logic [15:0] REMOTE_SETPOINT,
	// Host serial port register access
	input wire logic HOST_WR,
	input wire logic HOST_RD,
	input wire logic [15:0] HOST_ADDR,
	input wire logic [15:0] HOST_WDATA,
	input wire logic HOST_RESET_CMD,
	output logic [15:0] HOST_RDATA,
	output logic HOST_RVALID,
	// Aux serial port and programmer port read access to remote inputs
	input wire logic [RIO_IDX_W-1:0] AUX_RIO_IDX,
	output logic [15:0] AUX_RIO_DATA,
	input wire logic [RIO_IDX_W-1:0] PROG_RIO_IDX,
	output logic [15:0] PROG_RIO_DATA,
	// Field network channel one
	input wire logic RIO_IN_WE,
	input wire logic [RIO_IDX_W-1:0] RIO_IN_IDX,
	input wire logic [15:0] RIO_IN_DATA,
	output logic [RIO_MAX*16-1:0] RIO_OUT,
	// Field network channel two
	output logic NET_TWO_TX,
	output logic NET_TWO_TX_EN,
	// Lamps and contact indicators
	output logic LAMP_ONE,
	output logic LAMP_TWO,
	output logic LAMP_THREE,
	output logic LAMP_FOUR,
	output logic [2:0] CONTACT_LAMP,
	// Analog outputs one, two, four
	output logic [15:0] AOUT_ONE,
	output logic [15:0] AOUT_TWO,
	output logic [15:0] AOUT_FOUR,
	// Speed and fuel control
	output logic SPEED_LOSS_SHUTDOWN,
	output logic FUEL_RISE_ALLOW,
	output logic FUEL_FORCE_INCREASE
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic spare_a;
	logic reset_in;
	logic sfo;
	logic reset_rise;
	logic reset_pulse;
	logic [ALARM_W-1:0] alarm_latch;
	logic [SHUT_W-1:0] shut_latch;
	logic [15:0] aout_one_reg;
	logic [15:0] aout_two_reg;
	logic [15:0] aout_four_reg;
	logic [11:0] src_cfg;
	logic [15:0] rio_out_mem [RIO_MAX];
	logic [15:0] rio_in_mem [RIO_MAX];
	logic [15:0] next_aout_one;
	logic [15:0] next_aout_two;
	logic [15:0] next_aout_four;
	logic [15:0] speed_scaled;
	logic [15:0] ref_scaled;
	logic [15:0] fuel_scaled;
	logic both_lost;
	logic [15:0] rd_mux;
	logic [15:0] rio_in_off;
	logic [15:0] rio_out_off;

	// ----------------------------------------------------------------
	// Contact inputs
	// ----------------------------------------------------------------
	contact_qualifier u_spare_a (
		.clk(CLK),
		.rst_b(RST_B),
		.raw(SPARE_A_IN),
		.state(spare_a),
		.rise()
	);

	contact_qualifier u_alarm_reset (
		.clk(CLK),
		.rst_b(RST_B),
		.raw(ALARM_RESET_IN),
		.state(reset_in),
		.rise(reset_rise)
	);

	contact_qualifier u_speed_fail_ovr (
		.clk(CLK),
		.rst_b(RST_B),
		.raw(SPEED_FAIL_OVR_IN),
		.state(sfo),
		.rise()
	);

	// Indicator lamps follow the qualified TRUE state only
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			CONTACT_LAMP <= 3'h0;
		end else begin
			CONTACT_LAMP <= {sfo, reset_in, spare_a};
		end
	end

	// ----------------------------------------------------------------
	// Alarm reset request
	// ----------------------------------------------------------------
	// Contact is edge-only, so a held contact cannot keep latches clear; host and software resets act as levels
	assign reset_pulse = reset_rise | HOST_RESET_CMD | SW_RESET;

	// Latches: a condition present in the reset cycle stays latched
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			alarm_latch <= '0;
			shut_latch <= '0;
		end else if (reset_pulse) begin
			// Set wins: an abnormal condition keeps or sets its bit
			alarm_latch <= ALARM_COND & ALARM_CFG;
			shut_latch <= SHUT_COND & SHUT_CFG;
		end else begin
			alarm_latch <= alarm_latch | (ALARM_COND & ALARM_CFG);
			shut_latch <= shut_latch | (SHUT_COND & SHUT_CFG);
		end
	end

	// ----------------------------------------------------------------
	// Status lamps
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			LAMP_ONE <= 1'b0;
			LAMP_TWO <= 1'b0;
			LAMP_THREE <= 1'b0;
			LAMP_FOUR <= 1'b0;
		end else begin
			LAMP_ONE <= SPEED_PICKUP_ONE_FAIL;
			LAMP_TWO <= SPEED_PICKUP_TWO_FAIL;
			LAMP_THREE <= |alarm_latch;
			LAMP_FOUR <= |shut_latch | SPEED_LOSS_SHUTDOWN;
		end
	end

	// ----------------------------------------------------------------
	// Speed-fail override
	// ----------------------------------------------------------------
	// Direct-acting plants must hold the contact open while running
	assign both_lost = SPEED_PICKUP_ONE_FAIL & SPEED_PICKUP_TWO_FAIL;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			SPEED_LOSS_SHUTDOWN <= 1'b0;
			FUEL_RISE_ALLOW <= 1'b0;
			FUEL_FORCE_INCREASE <= 1'b0;
		end else begin
			SPEED_LOSS_SHUTDOWN <= both_lost & ~sfo;
			FUEL_RISE_ALLOW <= sfo | ~both_lost;
			FUEL_FORCE_INCREASE <= sfo & REVERSE_ACTING & both_lost;
		end
	end

	// ----------------------------------------------------------------
	// Host serial writes
	// ----------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			aout_one_reg <= REG_RESET_VAL;
			aout_two_reg <= REG_RESET_VAL;
			aout_four_reg <= REG_RESET_VAL;
			src_cfg <= '0;
		end else if (HOST_WR) begin
			case (HOST_ADDR)
				REG_AOUT_ONE: aout_one_reg <= HOST_WDATA;
				REG_AOUT_TWO: aout_two_reg <= HOST_WDATA;
				REG_AOUT_FOUR: aout_four_reg <= HOST_WDATA;
				REG_SRC_CFG: src_cfg <= HOST_WDATA[11:0];
				default: src_cfg <= src_cfg;
			endcase
		end
	end

	// Remote module outputs come only from host writes
	assign rio_out_off = HOST_ADDR - REG_RIO_OUT_BASE;

	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < RIO_MAX; i++) begin
				rio_out_mem[i] <= '0;
			end
		end else if (HOST_WR && HOST_ADDR >= REG_RIO_OUT_BASE
				&& rio_out_off < 16'(RIO_MAX)) begin
			rio_out_mem[rio_out_off[RIO_IDX_W-1:0]] <= HOST_WDATA;
		end
	end

	// Nine-module image of remote inputs; higher indices dropped
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			for (int i = 0; i < RIO_MAX; i++) begin
				rio_in_mem[i] <= '0;
			end
		end else if (RIO_IN_WE && RIO_IN_IDX < RIO_IDX_W'(RIO_MAX)) begin
			rio_in_mem[RIO_IN_IDX] <= RIO_IN_DATA;
		end
	end

	// Flatten remote outputs onto the network port
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			RIO_OUT <= '0;
		end else begin
			for (int i = 0; i < RIO_MAX; i++) begin
				RIO_OUT[i*16 +: 16] <= rio_out_mem[i];
			end
		end
	end

	// Second channel never transmits
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			NET_TWO_TX <= 1'b0;
			NET_TWO_TX_EN <= 1'b0;
		end else begin
			NET_TWO_TX <= 1'b0;
			NET_TWO_TX_EN <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Host serial reads
	// ----------------------------------------------------------------
	assign rio_in_off = HOST_ADDR - REG_RIO_IN_BASE;

	always_comb begin
		rd_mux = 16'h0000;
		if (HOST_ADDR == REG_AOUT_ONE) begin
			rd_mux = aout_one_reg;
		end else if (HOST_ADDR == REG_AOUT_TWO) begin
			rd_mux = aout_two_reg;
		end else if (HOST_ADDR == REG_AOUT_FOUR) begin
			rd_mux = aout_four_reg;
		end else if (HOST_ADDR == REG_SPARE_A) begin
			rd_mux = {15'h0000, spare_a};
		end else if (HOST_ADDR == REG_SRC_CFG) begin
			rd_mux = {4'h0, src_cfg};
		end else if (HOST_ADDR == REG_STATUS) begin
			rd_mux[ST_SPARE_A] = spare_a;
			rd_mux[ST_ALARM] = |alarm_latch;
			rd_mux[ST_SHUT] = |shut_latch;
			rd_mux[ST_SFO] = sfo;
		end else if (HOST_ADDR >= REG_RIO_IN_BASE && rio_in_off < 16'(RIO_MAX)) begin
			rd_mux = rio_in_mem[rio_in_off[RIO_IDX_W-1:0]];
		end else if (HOST_ADDR >= REG_RIO_OUT_BASE && rio_out_off < 16'(RIO_MAX)) begin
			rd_mux = rio_out_mem[rio_out_off[RIO_IDX_W-1:0]];
		end
	end

	// Read answer one cycle after the request
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			HOST_RDATA <= 16'h0000;
			HOST_RVALID <= 1'b0;
		end else begin
			HOST_RVALID <= HOST_RD;
			HOST_RDATA <= HOST_RD ? rd_mux : HOST_RDATA;
		end
	end

	// Aux serial and programmer ports see the same remote inputs
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			AUX_RIO_DATA <= 16'h0000;
			PROG_RIO_DATA <= 16'h0000;
		end else begin
			AUX_RIO_DATA <= (AUX_RIO_IDX < RIO_IDX_W'(RIO_MAX))
				? rio_in_mem[AUX_RIO_IDX] : 16'h0000;
			PROG_RIO_DATA <= (PROG_RIO_IDX < RIO_IDX_W'(RIO_MAX))
				? rio_in_mem[PROG_RIO_IDX] : 16'h0000;
		end
	end

	// ----------------------------------------------------------------
	// Analog outputs
	// ----------------------------------------------------------------
	// Clamp to default full scale; values above it saturate
	assign speed_scaled = (ENGINE_SPEED > SPEED_FULL_RPM) ? SPEED_FULL_RPM : ENGINE_SPEED;
	assign ref_scaled = (SPEED_REF > SPEED_FULL_RPM) ? SPEED_FULL_RPM : SPEED_REF;
	assign fuel_scaled = (FUEL_DEMAND > FUEL_FULL_PCT) ? FUEL_FULL_PCT : FUEL_DEMAND;

	aout_mux u_mux_one (
		.sel(src_cfg[SRC_ONE_LSB +: 3]),
		.dflt(SRC_SPEED),
		.speed(speed_scaled),
		.speed_ref(ref_scaled),
		.fuel(fuel_scaled),
		.rev_fuel(REV_FUEL_DEMAND),
		.torsion(TORSION_LEVEL),
		.remote_sp(REMOTE_SETPOINT),
		.serial_val(aout_one_reg),
		.value(next_aout_one)
	);

	aout_mux u_mux_two (
		.sel(src_cfg[SRC_TWO_LSB +: 3]),
		.dflt(SRC_SPEED_REF),
		.speed(speed_scaled),
		.speed_ref(ref_scaled),
		.fuel(fuel_scaled),
		.rev_fuel(REV_FUEL_DEMAND),
		.torsion(TORSION_LEVEL),
		.remote_sp(REMOTE_SETPOINT),
		.serial_val(aout_two_reg),
		.value(next_aout_two)
	);

	aout_mux u_mux_four (
		.sel(src_cfg[SRC_FOUR_LSB +: 3]),
		.dflt(SRC_FUEL),
		.speed(speed_scaled),
		.speed_ref(ref_scaled),
		.fuel(fuel_scaled),
		.rev_fuel(REV_FUEL_DEMAND),
		.torsion(TORSION_LEVEL),
		.remote_sp(REMOTE_SETPOINT),
		.serial_val(aout_four_reg),
		.value(next_aout_four)
	);

	// Register the selected values
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) begin
			AOUT_ONE <= 16'h0000;
			AOUT_TWO <= 16'h0000;
			AOUT_FOUR <= 16'h0000;
		end else begin
			AOUT_ONE <= next_aout_one;
			AOUT_TWO <= next_aout_two;
			AOUT_FOUR <= next_aout_four;
		end
	end

endmodule

// [pkg/gov_io_pkg.sv]
package gov_io_pkg;

	// ----------------------------------------------------------------
	// Holding register indices on the host serial port
	// ----------------------------------------------------------------
	localparam logic [15:0] REG_AOUT_ONE = 16'h0002;
	localparam logic [15:0] REG_AOUT_TWO = 16'h0003;
	localparam logic [15:0] REG_AOUT_FOUR = 16'h0004;
	localparam logic [15:0] REG_SPARE_A = 16'h0010;
	localparam logic [15:0] REG_SRC_CFG = 16'h0011;
	localparam logic [15:0] REG_STATUS = 16'h0012;
	localparam logic [15:0] REG_RIO_OUT_BASE = 16'h0020;
	localparam logic [15:0] REG_RIO_IN_BASE = 16'h0030;
	localparam logic [15:0] REG_RESET_VAL = 16'h0000;

	// ----------------------------------------------------------------
	// Analog output source codes
	// ----------------------------------------------------------------
	localparam logic [2:0] SRC_SPEED = 3'h1;
	localparam logic [2:0] SRC_SPEED_REF = 3'h2;
	localparam logic [2:0] SRC_FUEL = 3'h3;
	localparam logic [2:0] SRC_REV_FUEL = 3'h4;
	localparam logic [2:0] SRC_TORSION = 3'h5;
	localparam logic [2:0] SRC_REMOTE_SP = 3'h6;
	localparam logic [2:0] SRC_SERIAL = 3'h7;

	// Source field positions in the source configuration register
	localparam int SRC_ONE_LSB = 0;
	localparam int SRC_TWO_LSB = 4;
	localparam int SRC_FOUR_LSB = 8;

	// Default scaling: full scale of each default source
	localparam logic [15:0] SPEED_FULL_RPM = 16'd1300;
	localparam logic [15:0] FUEL_FULL_PCT = 16'd100;

	// ----------------------------------------------------------------
	// Remote I/O on the field network channel
	// ----------------------------------------------------------------
	localparam int RIO_MAX = 9;
	localparam int RIO_IDX_W = 4;

	// Alarm and shutdown latch widths
	localparam int ALARM_W = 8;
	localparam int SHUT_W = 8;

	// Status register bit positions
	localparam int ST_SPARE_A = 0;
	localparam int ST_ALARM = 1;
	localparam int ST_SHUT = 2;
	localparam int ST_SFO = 3;

endpackage

// [core/contact_qualifier.sv]
`timescale 1ns/1ps
module contact_qualifier
	import gov_io_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Raw contact and qualified state
	input wire logic raw,
	output logic state,
	output logic rise
);

	logic sync1;
	logic sync2;

	// ----------------------------------------------------------------
	// Two-stage sampling, then edge of the qualified level
	// ----------------------------------------------------------------
	// Synchroniser first stage is read only by the second
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
		end else begin
			sync1 <= raw;
			sync2 <= sync1;
		end
	end

	// Voltage present reads TRUE, open reads FALSE
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= 1'b0;
		end else begin
			state <= sync2;
		end
	end

	// One-cycle pulse on FALSE to TRUE only
	assign rise = sync2 & ~state;

endmodule

// [core/aout_mux.sv]
`timescale 1ns/1ps
module aout_mux
	import gov_io_pkg::*;
(
	// Selection code and candidate values
	input wire logic [2:0] sel,
	input wire logic [2:0] dflt,
	input wire logic [15:0] speed,
	input wire logic [15:0] speed_ref,
	input wire logic [15:0] fuel,
	input wire logic [15:0] rev_fuel,
	input wire logic [15:0] torsion,
	input wire logic [15:0] remote_sp,
	input wire logic [15:0] serial_val,
	output logic [15:0] value
);

	logic [2:0] eff;

	// Unconfigured code 0 falls back to the output's default source
	assign eff = (sel == 3'h0) ? dflt : sel;

	// ----------------------------------------------------------------
	// Source select
	// ----------------------------------------------------------------
	always_comb begin
		case (eff)
			SRC_SPEED: value = speed;
			SRC_SPEED_REF: value = speed_ref;
			SRC_FUEL: value = fuel;
			SRC_REV_FUEL: value = rev_fuel;
			SRC_TORSION: value = torsion;
			SRC_REMOTE_SP: value = remote_sp;
			SRC_SERIAL: value = serial_val;
			default: value = 16'h0000;
		endcase
	end

endmodule

// [verification/gov_discrete_io_monitor.sv]
`timescale 1ns/1ps
module gov_discrete_io_monitor
	import gov_io_pkg::*;
(
	// Clock, reset and contacts
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic SPARE_A_IN,
	input wire logic ALARM_RESET_IN,
	input wire logic SPEED_FAIL_OVR_IN,
	// Plant state and reset sources
	input wire logic SPEED_PICKUP_ONE_FAIL,
	input wire logic SPEED_PICKUP_TWO_FAIL,
	input wire logic REVERSE_ACTING,
	input wire logic [ALARM_W-1:0] ALARM_CFG,
	input wire logic [ALARM_W-1:0] ALARM_COND,
	input wire logic SW_RESET,
	input wire logic HOST_RESET_CMD,
	input wire logic [RIO_IDX_W-1:0] AUX_RIO_IDX,
	// Watched outputs
	input wire logic [15:0] AUX_RIO_DATA,
	input wire logic NET_TWO_TX,
	input wire logic NET_TWO_TX_EN,
	input wire logic LAMP_ONE,
	input wire logic LAMP_TWO,
	input wire logic LAMP_THREE,
	input wire logic [2:0] CONTACT_LAMP,
	input wire logic SPEED_LOSS_SHUTDOWN,
	input wire logic FUEL_RISE_ALLOW,
	input wire logic FUEL_FORCE_INCREASE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_B);
	logic [2:0] up_cnt;

	// Cycles since release; contact stages hold reset values until filled
	always_ff @(posedge CLK or negedge RST_B) begin
		if (!RST_B) up_cnt <= 3'h0;
		else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
	end

	// Both pickups lost with the override at a given level
	sequence s_lost(bit ov);
		(SPEED_PICKUP_ONE_FAIL && SPEED_PICKUP_TWO_FAIL && SPEED_FAIL_OVR_IN == ov)[*6];
	endsequence
	// Reset contact held well past its pulse, a fault comes and goes
	sequence s_held_fault;
		ALARM_RESET_IN[*6] ##1 (ALARM_RESET_IN && (ALARM_COND & ALARM_CFG) != '0)
			##1 (ALARM_RESET_IN && !SW_RESET && !HOST_RESET_CMD)[*4];
	endsequence
	// Fresh closure of the reset contact with every alarm condition normal
	sequence s_clean_reset;
		!ALARM_RESET_IN[*4] ##1 (ALARM_RESET_IN && ALARM_COND == '0)[*8];
	endsequence

	AST_LAMP_ONE: assert property (up_cnt != 3'h0 |-> LAMP_ONE == $past(SPEED_PICKUP_ONE_FAIL))
		else $error("lamp one does not follow pickup one");
	AST_LAMP_TWO: assert property (up_cnt != 3'h0 |-> LAMP_TWO == $past(SPEED_PICKUP_TWO_FAIL))
		else $error("lamp two does not follow pickup two");
	AST_CONTACT_LAMP: assert property (up_cnt == 3'h7 |->
		CONTACT_LAMP == $past({SPEED_FAIL_OVR_IN, ALARM_RESET_IN, SPARE_A_IN}, 4))
		else $error("contact lamps wrong");
	AST_RESET_CLEARS: assert property (s_clean_reset |-> !LAMP_THREE)
		else $error("alarm lamp not cleared by reset");
	AST_ONE_SHOT: assert property (s_held_fault |-> LAMP_THREE)
		else $error("held reset contact cleared a new alarm");
	AST_HOST_RESET: assert property ((HOST_RESET_CMD && ALARM_COND == '0) ##1
		(ALARM_COND == '0)[*3] |-> !LAMP_THREE) else $error("host reset ignored");
	AST_LOSS_SHUTDOWN: assert property (s_lost(1'b0) |-> SPEED_LOSS_SHUTDOWN)
		else $error("no shutdown on loss of both pickups");
	AST_OVR_FUEL: assert property (s_lost(1'b1) |-> FUEL_RISE_ALLOW)
		else $error("override does not allow fuel rise");
	AST_FORCE_INC: assert property (s_lost(1'b1) ##0 $past(REVERSE_ACTING) |-> FUEL_FORCE_INCREASE)
		else $error("fuel not forced up");
	AST_NO_FORCE: assert property (!REVERSE_ACTING[*2] |-> !FUEL_FORCE_INCREASE)
		else $error("fuel forced on direct plant");
	AST_RIO_RANGE: assert property (AUX_RIO_IDX >= 4'h9 |=> AUX_RIO_DATA == 16'h0000)
		else $error("remote index beyond nine gave data");
	AST_NET_TWO_IDLE: assert property (!NET_TWO_TX && !NET_TWO_TX_EN)
		else $error("second channel active");
endmodule
bind gov_discrete_io gov_discrete_io_monitor monitor (.*);

// [verification/field_model.sv]
`timescale 1ns/1ps
module field_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Commands from the bench
	input wire logic [2:0] close,
	input wire logic reverse,
	input wire logic send,
	input wire logic [3:0] idx,
	input wire logic [15:0] data,
	// Contacts and network words toward the device
	output logic [2:0] contact,
	output logic rio_we,
	output logic [3:0] rio_idx,
	output logic [15:0] rio_data
);
	// Override contact kept open on a direct-acting plant in normal running
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) contact <= 3'h0;
		else contact <= {close[2] & reverse, close[1:0]};
	end

	// One word per send; idle bus toggles so stale data never looks valid
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rio_we <= 1'b0;
			rio_idx <= 4'h0;
			rio_data <= 16'h0000;
		end else begin
			rio_we <= send;
			rio_idx <= send ? idx : ~rio_idx;
			rio_data <= send ? data : ~rio_data;
		end
	end
endmodule

// [verification/gov_discrete_io_test.sv]
`timescale 1ns/1ps
module gov_discrete_io_test;
	import gov_io_pkg::*;
	logic CLK, RST_B, SPEED_PICKUP_ONE_FAIL, SPEED_PICKUP_TWO_FAIL, REVERSE_ACTING, SW_RESET;
	logic [ALARM_W-1:0] ALARM_CFG, ALARM_COND, SHUT_CFG, SHUT_COND;
	logic [15:0] ENGINE_SPEED, SPEED_REF, FUEL_DEMAND, REV_FUEL_DEMAND, TORSION_LEVEL;
	logic [15:0] REMOTE_SETPOINT, HOST_ADDR, HOST_WDATA, HOST_RDATA, AUX_RIO_DATA;
	logic [15:0] PROG_RIO_DATA, AOUT_ONE, AOUT_TWO, AOUT_FOUR, RIO_IN_DATA, rio_d;
	logic HOST_WR, HOST_RD, HOST_RESET_CMD, HOST_RVALID, RIO_IN_WE, NET_TWO_TX, NET_TWO_TX_EN;
	logic LAMP_ONE, LAMP_TWO, LAMP_THREE, LAMP_FOUR, SPEED_LOSS_SHUTDOWN, FUEL_RISE_ALLOW;
	logic FUEL_FORCE_INCREASE, send;
	logic [RIO_IDX_W-1:0] AUX_RIO_IDX, PROG_RIO_IDX, RIO_IN_IDX, rio_i;
	logic [RIO_MAX*16-1:0] RIO_OUT;
	logic [2:0] CONTACT_LAMP, close, contact;
	wire logic SPARE_A_IN = contact[0];
	wire logic ALARM_RESET_IN = contact[1];
	wire logic SPEED_FAIL_OVR_IN = contact[2];
	int num_errors = 0;
	int checked = 0;
	int mirror[int];
	int rio_in[10];
	logic [15:0] src_val[8];

	// Clock, device and far side
	always #5 CLK = ~CLK;
	gov_discrete_io dut (.*);
	field_model field (.clk(CLK), .rst_b(RST_B), .close(close), .reverse(REVERSE_ACTING),
		.send(send), .idx(rio_i), .data(rio_d), .contact(contact), .rio_we(RIO_IN_WE),
		.rio_idx(RIO_IN_IDX), .rio_data(RIO_IN_DATA));

	// Comparison, settle and host bus helpers
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask
	task automatic host_wr(logic [15:0] a, logic [15:0] d);
		@(posedge CLK);
		HOST_WR <= 1'b1;
		HOST_ADDR <= a;
		HOST_WDATA <= d;
		@(posedge CLK);
		HOST_WR <= 1'b0;
		mirror[a] = d;
	endtask
	task automatic host_chk(logic [15:0] a, logic [15:0] exp);
		@(posedge CLK);
		HOST_RD <= 1'b1;
		HOST_ADDR <= a;
		@(posedge CLK);
		HOST_RD <= 1'b0;
		#1;
		chk("host rvalid", 16'h0001, {15'h0, HOST_RVALID});
		chk("host rdata", exp, HOST_RDATA);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Hang guard, far longer than the sequence needs
	initial begin
		repeat (5000) @(posedge CLK);
		num_errors++;
		final_report();
	end

	// Main sequence
	initial begin
		CLK = 1'b0;
		RST_B = 1'b0;
		{SPEED_PICKUP_ONE_FAIL, SPEED_PICKUP_TWO_FAIL, REVERSE_ACTING, SW_RESET, ALARM_CFG,
			ALARM_COND, SHUT_CFG, SHUT_COND, HOST_WR, HOST_RD, HOST_RESET_CMD, HOST_ADDR,
			HOST_WDATA, send, rio_i, rio_d, close, AUX_RIO_IDX, PROG_RIO_IDX, ENGINE_SPEED,
			SPEED_REF, FUEL_DEMAND, REV_FUEL_DEMAND, TORSION_LEVEL, REMOTE_SETPOINT} = '0;
		void'($urandom(59));
		foreach (src_val[i]) src_val[i] = 16'($urandom_range(99));
		repeat (16) @(posedge CLK);
		RST_B <= 1'b1;
		for (int r = 2; r <= 4; r++) host_wr(16'(r), 16'($urandom_range(99)));
		for (int r = 2; r <= 4; r++) host_chk(16'(r), 16'(mirror[r]));
		host_chk(16'h0099, 16'h0000);
		$display("test registers done");
		@(posedge CLK);
		{ENGINE_SPEED, SPEED_REF, FUEL_DEMAND} <= {src_val[1], src_val[2], src_val[3]};
		{REV_FUEL_DEMAND, TORSION_LEVEL, REMOTE_SETPOINT} <= {src_val[4], src_val[5], src_val[6]};
		for (int c = 0; c < 8; c++) begin
			host_wr(REG_SRC_CFG, 16'(c * 16'h0111));
			tick(3);
			chk("aout one", c == 7 ? 16'(mirror[2]) : src_val[c == 0 ? 1 : c], AOUT_ONE);
			chk("aout two", c == 7 ? 16'(mirror[3]) : src_val[c == 0 ? 2 : c], AOUT_TWO);
			chk("aout four", c == 7 ? 16'(mirror[4]) : src_val[c == 0 ? 3 : c], AOUT_FOUR);
		end
		host_wr(REG_SRC_CFG, 16'h0000);
		ENGINE_SPEED <= 16'h0FFF;
		FUEL_DEMAND <= 16'h00C8;
		tick(3);
		chk("speed full scale", SPEED_FULL_RPM, AOUT_ONE);
		chk("fuel full scale", FUEL_FULL_PCT, AOUT_FOUR);
		$display("test analog sources done");
		for (int k = 0; k < 4; k++) begin
			@(posedge CLK);
			{SPEED_PICKUP_TWO_FAIL, SPEED_PICKUP_ONE_FAIL} <= 2'(k);
			close <= 3'(k + 1);
			tick(7);
			chk("pickup lamps", 16'(k), {14'h0, LAMP_TWO, LAMP_ONE});
			chk("contact lamps", 16'((k + 1) & 3), {13'h0, CONTACT_LAMP});
			host_chk(REG_SPARE_A, 16'((k + 1) & 1));
			if (k == 3) chk("loss shutdown", 16'h0003, {14'h0, LAMP_FOUR, SPEED_LOSS_SHUTDOWN});
		end
		$display("test lamps and contacts done");
		@(posedge CLK);
		{SPEED_PICKUP_TWO_FAIL, SPEED_PICKUP_ONE_FAIL} <= 2'h0;
		close <= 3'h0;
		{ALARM_CFG, ALARM_COND, SHUT_CFG, SHUT_COND} <= {8'h03, 8'h03, 8'h01, 8'h01};
		@(posedge CLK);
		{ALARM_COND, SHUT_COND} <= {8'h02, 8'h00};
		close <= 3'h2;
		tick(12);
		chk("alarm kept while abnormal", 16'h0001, {15'h0, LAMP_THREE});
		@(posedge CLK);
		ALARM_COND <= 8'h00;
		tick(12);
		chk("alarm kept while contact held", 16'h0001, {15'h0, LAMP_THREE});
		@(posedge CLK);
		HOST_RESET_CMD <= 1'b1;
		@(posedge CLK);
		HOST_RESET_CMD <= 1'b0;
		tick(4);
		chk("lamps after host reset", 16'h0000, {14'h0, LAMP_FOUR, LAMP_THREE});
		@(posedge CLK);
		ALARM_COND <= 8'h01;
		@(posedge CLK);
		ALARM_COND <= 8'h00;
		SW_RESET <= 1'b1;
		@(posedge CLK);
		SW_RESET <= 1'b0;
		tick(3);
		chk("alarm after software reset", 16'h0000, {15'h0, LAMP_THREE});
		@(posedge CLK);
		ALARM_COND <= 8'h02;
		SW_RESET <= 1'b1;
		@(posedge CLK);
		ALARM_COND <= 8'h00;
		SW_RESET <= 1'b0;
		tick(3);
		chk("alarm set during reset", 16'h0001, {15'h0, LAMP_THREE});
		$display("test alarm reset done");
		@(posedge CLK);
		REVERSE_ACTING <= 1'b1;
		close <= 3'h4;
		tick(6);
		@(posedge CLK);
		{SPEED_PICKUP_TWO_FAIL, SPEED_PICKUP_ONE_FAIL} <= 2'h3;
		tick(8);
		chk("override", 16'h0003, {13'h0, SPEED_LOSS_SHUTDOWN, FUEL_FORCE_INCREASE, FUEL_RISE_ALLOW});
		chk("channel two", 16'h0000, {14'h0, NET_TWO_TX, NET_TWO_TX_EN});
		$display("test override done");
		for (int i = 0; i < 10; i++) begin
			@(posedge CLK);
			rio_in[i] = $urandom_range(16'hFFFF);
			send <= 1'b1;
			rio_i <= 4'(i);
			rio_d <= 16'(rio_in[i]);
			@(posedge CLK);
			send <= 1'b0;
		end
		for (int i = 0; i < 10; i++) begin
			@(posedge CLK);
			AUX_RIO_IDX <= 4'(i);
			PROG_RIO_IDX <= 4'(9 - i);
			tick(2);
			chk("aux remote", i < 9 ? 16'(rio_in[i]) : 16'h0000, AUX_RIO_DATA);
			chk("prog remote", i > 0 ? 16'(rio_in[9 - i]) : 16'h0000, PROG_RIO_DATA);
			if (i < 9) host_chk(REG_RIO_IN_BASE + 16'(i), 16'(rio_in[i]));
			if (i < 9) host_wr(REG_RIO_OUT_BASE + 16'(i), ~16'(rio_in[i]));
		end
		tick(2);
		for (int i = 0; i < 9; i++) chk("remote out", ~16'(rio_in[i]), RIO_OUT[i*16 +: 16]);
		$display("test remote modules done");
		final_report();
	end
endmodule
